// ---- include/vpl_pkg.sv ----
/*
 package for the voice port and link master register bank: offsets, field
 positions, reset values and bus carriers.
 assumes an axi4-lite master with 32-bit data and one clock.
*/
// What this block does
// R1 - voice config bit0 enables voice transmit
// R2 - voice config bit1 selects transmit port
// R3 - voice config bit2 enables voice receive
// R4 - voice config bit3 selects receive port
// R5 - bits 4-7 choose transmit timeslot
// R6 - bits 8-11 choose receive timeslot
// R7 - bit12 enables voice transparent mode
// R8 - main reset clears all; secondary resets ignored
// R9 - flag register reports read-only buffer flags
// R10 - empty flags rise after masters reach idle
// R11 - control bits 0,1 request transmit abort
// R12 - control bits 2,3 report receive abort
// R13 - control bits 4,5 mark transmit end
// R14 - control bits 6,7 report received end
// R15 - enable bits gate flags one to one
// R16 - link condition merged onto active-low line
// R17 - each master unit runs only when enabled
// R18 - link condition is plain level or
package vpl_pkg;
    localparam logic [3:0]  VPL_OFF_VOICE_CFG = 4'h0;
    localparam logic [3:0]  VPL_OFF_FLAGS     = 4'h4;
    localparam logic [3:0]  VPL_OFF_CTRL      = 4'h8;
    localparam logic [3:0]  VPL_OFF_IRQ_EN    = 4'hC;
    localparam int          VPL_CFG_W         = 13;
    localparam int          VPL_FLG_W         = 8;
    localparam logic [12:0] VPL_CFG_RESET     = 13'h0000;
    localparam logic [7:0]  VPL_FLG_RESET     = 8'h00;
    localparam logic [7:0]  VPL_CTRL_RESET    = 8'h00;
    localparam logic [7:0]  VPL_EN_RESET      = 8'h00;
    localparam logic [7:0]  VPL_CTRL_WMASK    = 8'h33;
    localparam logic [1:0]  VPL_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  VPL_RESP_SLVERR   = 2'h2;
    localparam logic [2:0]  VPL_CLKMODE_ZERO  = 3'h0;
    localparam int          VPL_INIT_CYCLES   = 4;
    typedef struct packed {
        logic       passthroughOn;
        logic [3:0] recvTimeslot;
        logic [3:0] sendTimeslot;
        logic       recvPortSel;
        logic       recvOn;
        logic       sendPortSel;
        logic       sendOn;
    } vpl_voice_cfg_t;
    typedef struct packed {
        logic cmdIndBOutEmpty;
        logic cmdIndBInFull;
        logic cmdIndAOutEmpty;
        logic cmdIndAInFull;
        logic monitorBOutEmpty;
        logic monitorBInFull;
        logic monitorAOutEmpty;
        logic monitorAInFull;
    } vpl_flags_t;
    typedef struct packed {
        logic monitorBRecvMsgEnd;
        logic monitorARecvMsgEnd;
        logic monitorBSendMsgEnd;
        logic monitorASendMsgEnd;
        logic monitorBRecvAbort;
        logic monitorARecvAbort;
        logic monitorBSendAbort;
        logic monitorASendAbort;
    } vpl_ctrl_t;
endpackage

// ---- logic/vpl_regs.sv ----
/*
 voice port and link master register bank, an axi4-lite slave.
 assumes the link masters drive their events as synchronous one-cycle
 pulses and take abort and message-end requests as levels.
*/
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
module vpl_regs (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // axi4-lite write address, data and response
    input  wire logic [3:0]              awaddr,
    input  wire logic                    awvalid,
    output logic                         awready,
    input  wire logic [31:0]             wdata,
    input  wire logic [3:0]              wstrb,
    input  wire logic                    wvalid,
    output logic                         wready,
    output logic [1:0]                   bresp,
    output logic                         bvalid,
    input  wire logic                    bready,
    // axi4-lite read
    input  wire logic [3:0]              araddr,
    input  wire logic                    arvalid,
    output logic                         arready,
    output logic [31:0]                  rdata,
    output logic [1:0]                   rresp,
    output logic                         rvalid,
    input  wire logic                    rready,
    // link configuration seen from outside
    input  wire logic                    linkOn,
    input  wire logic [2:0]              linkClockMode,
    input  wire logic [1:0]              linkMasterUnitOn,
    // link master events
    input  wire vpl_pkg::vpl_flags_t     flagSet,
    input  wire vpl_pkg::vpl_flags_t     flagClr,
    input  wire logic [1:0]              recvAbortSet,
    input  wire logic [1:0]              recvMsgEndSet,
    input  wire logic [1:0]              recvEventClr,
    input  wire logic [1:0]              sendDone,
    // voice port controls
    output vpl_pkg::vpl_voice_cfg_t      voiceCfg,
    // link master requests
    output logic [1:0]                   sendAbortReq,
    output logic [1:0]                   sendMsgEndReq,
    // interrupts
    output logic                         linkIrqCondition,
    output logic                         combinedIrqLine_n
);
    import vpl_pkg::*;

    logic                 rstSync1;
    logic                 rstSync2;
    vpl_voice_cfg_t       cfgReg;
    vpl_flags_t           flagReg;
    vpl_ctrl_t            ctrlReg;
    logic [7:0]           enReg;
    logic [2:0]           initCnt;
    logic [1:0]           initDone;
    logic                 awHeld;
    logic                 wHeld;
    logic [3:0]           awAddrHeld;
    logic [31:0]          wDataHeld;
    logic [3:0]           wStrbHeld;

    // two-stage release of the async reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end
        else
        begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end

    function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                res[i*8 +: 8] = nw[i*8 +: 8];
        return res;
    endfunction

    // write channel capture
    wire         awTake   = awvalid && awready;
    wire         wTake    = wvalid && wready;
    wire         doWrite  = awHeld && wHeld && !bvalid;
    wire         wrCfg    = doWrite && (awAddrHeld == VPL_OFF_VOICE_CFG);
    wire         wrCtrl   = doWrite && (awAddrHeld == VPL_OFF_CTRL);
    wire         wrEn     = doWrite && (awAddrHeld == VPL_OFF_IRQ_EN);
    wire         wrFlags  = doWrite && (awAddrHeld == VPL_OFF_FLAGS);
    wire         wrMapped = wrCfg || wrCtrl || wrEn || wrFlags;
    wire [31:0]  cfgMerged  = strb_merge({19'h0, cfgReg}, wDataHeld, wStrbHeld);
    wire [31:0]  ctrlMerged = strb_merge({24'h0, ctrlReg}, wDataHeld, wStrbHeld);
    wire [31:0]  enMerged   = strb_merge({24'h0, enReg}, wDataHeld, wStrbHeld);

    always_ff @(posedge clk or negedge rstSync2)
    begin
        if (!rstSync2)
        begin
            awHeld     <= 1'b0;
            wHeld      <= 1'b0;
            awAddrHeld <= 4'h0;
            wDataHeld  <= 32'h00000000;
            wStrbHeld  <= 4'h0;
            awready    <= 1'b0;
            wready     <= 1'b0;
            bvalid     <= 1'b0;
            bresp      <= VPL_RESP_OKAY;
        end
        else
        begin
            awready <= !awHeld && !awTake && !bvalid && !doWrite;
            wready  <= !wHeld && !wTake && !bvalid && !doWrite;
            if (awTake)
            begin
                awHeld     <= 1'b1;
                awAddrHeld <= {awaddr[3:2], 2'h0};
            end
            if (wTake)
            begin
                wHeld     <= 1'b1;
                wDataHeld <= wdata;
                wStrbHeld <= wstrb;
            end
            if (doWrite)
            begin
                awHeld <= 1'b0;
                wHeld  <= 1'b0;
                bvalid <= 1'b1;
                bresp  <= wrMapped ? VPL_RESP_OKAY : VPL_RESP_SLVERR;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    // voice configuration register
    always_ff @(posedge clk or negedge rstSync2)
    begin
        if (!rstSync2)
            cfgReg <= VPL_CFG_RESET; // R8
        else if (wrCfg)
            cfgReg <= cfgMerged[VPL_CFG_W-1:0]; // R1 R2 R3 R4 R5 R6 R7
    end

    // interrupt enable register
    always_ff @(posedge clk or negedge rstSync2)
    begin
        if (!rstSync2)
            enReg <= VPL_EN_RESET; // R8
        else if (wrEn)
            enReg <= enMerged[7:0];
    end

    // initial state of each master before empty flags rise
    wire initGo = linkOn && (linkClockMode == VPL_CLKMODE_ZERO) && (linkMasterUnitOn == 2'h0);
    always_ff @(posedge clk or negedge rstSync2)
    begin
        if (!rstSync2)
        begin
            initCnt  <= 3'h0;
            initDone <= 2'h0;
        end
        else if (!initGo)
            initCnt <= 3'h0;
        else if (initCnt != 3'(VPL_INIT_CYCLES))
            initCnt <= initCnt + 3'h1;
        else
            initDone <= 2'h3; // R10
    end

    // flag register, set wins over clear
    wire [1:0]   unitOn    = linkMasterUnitOn;
    wire [7:0]   unitMask  = {unitOn[1], unitOn[1], unitOn[0], unitOn[0],
                              unitOn[1], unitOn[1], unitOn[0], unitOn[0]};
    wire         initRise  = initGo && (initCnt == 3'(VPL_INIT_CYCLES)) && (initDone == 2'h0);
    wire [7:0]   emptyInit = initRise ? 8'hAA : 8'h00;
    wire [7:0]   next_flag = ((flagReg & ~(flagClr & unitMask)) | (flagSet & unitMask))
                             | emptyInit;
    always_ff @(posedge clk or negedge rstSync2)
    begin
        if (!rstSync2)
            flagReg <= VPL_FLG_RESET; // R8
        else
            flagReg <= next_flag; // R9 R10 R17
    end

    // control register
    wire [1:0] swAbort  = ctrlMerged[1:0];
    wire [1:0] swMsgEnd = ctrlMerged[5:4];
    wire [1:0] next_sendAbort  = (wrCtrl ? swAbort : {ctrlReg.monitorBSendAbort,
                                 ctrlReg.monitorASendAbort}) & ~(sendDone & unitOn);
    wire [1:0] next_sendMsgEnd = (wrCtrl ? swMsgEnd : {ctrlReg.monitorBSendMsgEnd,
                                 ctrlReg.monitorASendMsgEnd}) & ~(sendDone & unitOn);
    wire [1:0] next_recvAbort  = ({ctrlReg.monitorBRecvAbort, ctrlReg.monitorARecvAbort}
                                 & ~recvEventClr) | (recvAbortSet & unitOn);
    wire [1:0] next_recvMsgEnd = ({ctrlReg.monitorBRecvMsgEnd, ctrlReg.monitorARecvMsgEnd}
                                 & ~recvEventClr) | (recvMsgEndSet & unitOn);
    always_ff @(posedge clk or negedge rstSync2)
    begin
        if (!rstSync2)
            ctrlReg <= VPL_CTRL_RESET; // R8
        else
            ctrlReg <= {next_recvMsgEnd, next_sendMsgEnd,
                        next_recvAbort, next_sendAbort}; // R11 R12 R13 R14
    end

    // read channel
    wire [3:0]  rdAddr = {araddr[3:2], 2'h0};
    wire        arTake = arvalid && arready;
    wire [31:0] rdMux  = (rdAddr == VPL_OFF_VOICE_CFG) ? {19'h0, cfgReg} :
                         (rdAddr == VPL_OFF_FLAGS)     ? {24'h0, flagReg} :
                         (rdAddr == VPL_OFF_CTRL)      ? {24'h0, ctrlReg} :
                         (rdAddr == VPL_OFF_IRQ_EN)    ? {24'h0, enReg} : 32'h00000000;
    always_ff @(posedge clk or negedge rstSync2)
    begin
        if (!rstSync2)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= VPL_RESP_OKAY;
        end
        else
        begin
            arready <= !rvalid && !arTake;
            if (arTake)
            begin
                rvalid <= 1'b1;
                rdata  <= rdMux;
                rresp  <= VPL_RESP_OKAY;
            end
            else if (rvalid && rready)
                rvalid <= 1'b0;
        end
    end

    // outputs and interrupt condition
    wire gatedAny = |(flagReg & enReg); // R15 R18
    always_ff @(posedge clk or negedge rstSync2)
    begin
        if (!rstSync2)
        begin
            voiceCfg          <= VPL_CFG_RESET;
            sendAbortReq      <= 2'h0;
            sendMsgEndReq     <= 2'h0;
            linkIrqCondition  <= 1'b0;
            combinedIrqLine_n <= 1'b1;
        end
        else
        begin
            voiceCfg          <= cfgReg;
            sendAbortReq      <= {ctrlReg.monitorBSendAbort, ctrlReg.monitorASendAbort} & unitOn;
            sendMsgEndReq     <= {ctrlReg.monitorBSendMsgEnd, ctrlReg.monitorASendMsgEnd}
                                 & unitOn; // R17
            linkIrqCondition  <= gatedAny; // R18
            combinedIrqLine_n <= !gatedAny; // R16
        end
    end
endmodule

// ---- testbench/vpl_regs_sva.sv ----
/*
 checker for the voice port and link master register bank.
 assumes it is bound to vpl_regs and sees only its ports.
*/
module vpl_regs_sva
    import vpl_pkg::*;
(
    // clock and reset
    input wire logic           clk,
    input wire logic           rst_n,
    // register bus
    input wire logic [3:0]     awaddr,
    input wire logic           awvalid,
    input wire logic           awready,
    input wire logic [31:0]    wdata,
    input wire logic [3:0]     wstrb,
    input wire logic           wvalid,
    input wire logic           wready,
    input wire logic [1:0]     bresp,
    input wire logic           bvalid,
    input wire logic           bready,
    input wire logic           arvalid,
    input wire logic           arready,
    input wire logic           rvalid,
    input wire logic           rready,
    // block side
    input wire logic [1:0]     linkMasterUnitOn,
    input wire vpl_voice_cfg_t voiceCfg,
    input wire logic [1:0]     sendAbortReq,
    input wire logic [1:0]     sendMsgEndReq,
    input wire logic           linkIrqCondition,
    input wire logic           combinedIrqLine_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire wrGo = awvalid && awready && wvalid && wready;
    wire fullCfg = wrGo && awaddr[3:2] == 2'h0 && wstrb == 4'hF;
    wire enOff = wrGo && awaddr[3:2] == 2'h3 && wstrb[0] && wdata[7:0] == 8'h00;

    irq_polarity_a: assert property (combinedIrqLine_n == !linkIrqCondition)
        else $error("irq line not inverse of condition");
    cfg_update_a: assert property (fullCfg |-> ##5 voiceCfg == $past(wdata[12:0], 5))
        else $error("voice settings not taken from write");
    irq_gate_a: assert property (enOff |-> ##6 !linkIrqCondition)
        else $error("irq stays with all enables off");
    send_gate_a: assert property (((sendAbortReq | sendMsgEndReq)
        & ~$past(linkMasterUnitOn)) == 2'h0) else $error("send request from unit off");
    wr_answer_a: assert property (wrGo |-> ##2 bvalid) else $error("write answer late");
    rd_answer_a: assert property (arvalid && arready |=> rvalid) else $error("read answer late");
    rd_release_a: assert property (rvalid && rready |=> !rvalid ##1 arready)
        else $error("read not released");
    wr_release_a: assert property (bvalid && bready |=> !bvalid) else $error("bvalid held");
    wr_okay_a: assert property (bvalid |-> bresp == VPL_RESP_OKAY) else $error("bad bresp");
endmodule

// ---- testbench/vpl_regs_test.sv ----
/*
 self-checking bench for the voice port and link master register bank.
 assumes the package and the checker are compiled before this file.
*/
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin numErrors++; \
    $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module vpl_regs_test
    import vpl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic linkOn = 1'b0, awready, wready, bvalid, arready, rvalid, irq, irq_n;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, rdata, d, w;
    logic [1:0] unitOn = 2'h0, rAb = 2'h0, rEnd = 2'h0, rClr = 2'h0, sDone = 2'h0;
    logic [1:0] bresp, rresp, abortReq, endReq, br, rr;
    logic [2:0] clkMode = 3'h0;
    vpl_flags_t flagSet = '0, flagClr = '0;
    vpl_voice_cfg_t voiceCfg;
    int numErrors = 0, compares = 0;

    vpl_regs i_dut (.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready(1'b1), .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready(1'b1), .linkOn, .linkClockMode(clkMode),
        .linkMasterUnitOn(unitOn), .flagSet, .flagClr, .recvAbortSet(rAb),
        .recvMsgEndSet(rEnd), .recvEventClr(rClr), .sendDone(sDone), .voiceCfg,
        .sendAbortReq(abortReq), .sendMsgEndReq(endReq), .linkIrqCondition(irq),
        .combinedIrqLine_n(irq_n));

    initial
    begin
        forever #25 clk = ~clk;
    end

    task automatic report_and_stop();
        if (numErrors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic tmo(input int n);
        if (n >= 40)
        begin
            numErrors++;
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 40);
        br = bresp;
        tmo(n);
    endtask

    task automatic rd(input logic [3:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 40);
        d = rdata;
        rr = rresp;
        tmo(n);
    endtask

    // one-cycle event pulses, then time for flags and irq to settle
    task automatic ev(input logic [7:0] s, input logic [7:0] c, input logic [7:0] r);
        flagSet <= vpl_flags_t'(s);
        flagClr <= vpl_flags_t'(c);
        {rAb, rEnd, rClr, sDone} <= r;
        @(posedge clk);
        flagSet <= '0;
        flagClr <= '0;
        {rAb, rEnd, rClr, sDone} <= 8'h00;
        repeat (3) @(posedge clk);
    endtask

    function automatic vpl_voice_cfg_t vexp(input logic [31:0] v);
        return '{passthroughOn: v[12], recvTimeslot: v[11:8], sendTimeslot: v[7:4],
            recvPortSel: v[3], recvOn: v[2], sendPortSel: v[1], sendOn: v[0]};
    endfunction

    // every register and block-side output at its reset value
    task automatic chk_zero();
        for (int i = 0; i < 4; i++)
        begin
            rd(4'(i * 4));
            `CHK(d, 32'h0)
            `CHK(rr, VPL_RESP_OKAY)
        end
        `CHK(voiceCfg, 13'h0)
        `CHK({irq, irq_n, abortReq, endReq}, 6'h10)
    endtask

    initial
    begin
        void'($urandom(32'hC1BF6FC1));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk_zero();
        for (int k = 0; k < 12; k++)
        begin
            w = k ? $urandom : 32'hFFFFFFFF;
            wr(VPL_OFF_VOICE_CFG, w);
            rd(VPL_OFF_VOICE_CFG);
            `CHK(d, {19'h0, w[12:0]})
            `CHK(voiceCfg, vexp(w))
        end
        clkMode <= 3'(1 + $urandom % 7);
        linkOn <= 1'b1;
        repeat (8) @(posedge clk);
        rd(VPL_OFF_FLAGS);
        `CHK(d, 32'h0)
        clkMode <= 3'h0;
        repeat (8) @(posedge clk);
        wr(VPL_OFF_FLAGS, 32'hFF);
        `CHK(br, VPL_RESP_OKAY)
        rd(VPL_OFF_FLAGS);
        `CHK(d, 32'hAA)
        wr(VPL_OFF_IRQ_EN, 32'h02);
        repeat (3) @(posedge clk);
        `CHK({irq, irq_n}, 2'b10)
        wr(VPL_OFF_IRQ_EN, 32'h55);
        repeat (3) @(posedge clk);
        `CHK({irq, irq_n}, 2'b01)
        unitOn <= 2'b11;
        ev(8'h01, 8'h00, 8'h00);
        `CHK({irq, irq_n}, 2'b10)
        ev(8'h00, 8'h01, 8'h00);
        `CHK({irq, irq_n}, 2'b01)
        wr(VPL_OFF_CTRL, 32'hFF);
        rd(VPL_OFF_CTRL);
        `CHK(d, 32'h33)
        `CHK({abortReq, endReq}, 4'hF)
        ev(8'h00, 8'h00, 8'h60);
        rd(VPL_OFF_CTRL);
        `CHK(d, 32'hB7)
        ev(8'h00, 8'h00, 8'h03);
        rd(VPL_OFF_CTRL);
        `CHK(d, 32'h84)
        `CHK({abortReq, endReq}, 4'h0)
        ev(8'h00, 8'h00, 8'h0C);
        rd(VPL_OFF_CTRL);
        `CHK(d, 32'h0)
        unitOn <= 2'b10;
        ev(8'h10, 8'h00, 8'h00);
        ev(8'h04, 8'h00, 8'h00);
        rd(VPL_OFF_FLAGS);
        `CHK(d, 32'hAE)
        `CHK({irq, irq_n}, 2'b10)
        wr(VPL_OFF_IRQ_EN, 32'h00);
        repeat (3) @(posedge clk);
        `CHK({irq, irq_n}, 2'b01)
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk_zero();
        report_and_stop();
    end
endmodule
bind vpl_regs vpl_regs_sva i_sva (.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rvalid,
    .rready, .linkMasterUnitOn, .voiceCfg, .sendAbortReq, .sendMsgEndReq,
    .linkIrqCondition, .combinedIrqLine_n);
